// *** core/hrr_pkg.sv ***
// Shared types and constants for the hub repeater port routing core
package hrr_pkg;

	// Default count of downstream facing ports
	localparam int HRR_NUM_PORTS_DEF = 4;

	// Reset value of the high-speed mode flag
	localparam logic HRR_HS_MODE_RST = 1'b0;

	// Repeater connectivity states
	typedef enum logic [1:0] {
		HRR_IDLE,
		HRR_UP,
		HRR_DOWN
	} hrr_state_e;

endpackage

// *** core/hrr_pick.sv ***
// Fixed-priority picker: lowest numbered requesting port wins
module hrr_pick
	import hrr_pkg::*;
#(
	parameter int N = HRR_NUM_PORTS_DEF
) (
	input  wire logic [N-1:0] req_in,
	output logic      [N-1:0] gnt_out,
	output logic              any_out
);

	initial begin
		if (N < 1) begin
			$error("hrr_pick needs at least one port");
		end
	end

	// [RQ15] Deterministic single winner
	always_comb begin
		gnt_out = '0;
		any_out = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (req_in[i] && !any_out) begin
				gnt_out[i] = 1'b1;
				any_out    = 1'b1;
			end
		end
	end

endmodule

// *** core/hrr_core.sv ***
// Hub repeater speed selection, port routing and packet connectivity
// What this block does
// [RQ1] High-speed upstream makes the hub high-speed
// [RQ2] Full-speed upstream makes the hub full-speed
// [RQ3] Full/low upstream disables translator and HS repeater
// [RQ4] Full/low upstream routes every port to repeater
// [RQ5] High-speed upstream stops the full/low repeater
// [RQ6] HS device port goes to HS repeater
// [RQ7] Full/low device under HS goes to translator
// [RQ8] Translator path takes splits toward full/low devices
// [RQ9] One upstream port plus downstream ports
// [RQ10] Idle: no connection, all repeater-routed ports receiving
// [RQ11] Downstream start connects that port upstream only
// [RQ12] Upstream start broadcasts to enabled repeater-routed ports
// [RQ13] Disabled ports never get downstream traffic
// [RQ14] Packet end tears down back to idle
// [RQ15] Simultaneous starts: one port, fixed priority
module hrr_core
	import hrr_pkg::*;
#(
	parameter int NUM_PORTS = HRR_NUM_PORTS_DEF
) (
	input  wire logic                 CLK_SYS_IN,
	input  wire logic                 RST_N_IN,
	input  wire logic                 UP_CONNECTED_IN,
	input  wire logic                 UP_HIGH_SPEED_IN,
	input  wire logic [NUM_PORTS-1:0] DN_ENABLED_IN,
	input  wire logic [NUM_PORTS-1:0] DN_HIGH_SPEED_IN,
	input  wire logic                 UP_SOP_IN,
	input  wire logic                 UP_EOP_IN,
	input  wire logic [NUM_PORTS-1:0] DN_SOP_IN,
	input  wire logic [NUM_PORTS-1:0] DN_EOP_IN,
	output logic                      HS_MODE_OUT,
	output logic                      FS_MODE_OUT,
	output logic                      TT_ACTIVE_OUT,
	output logic                      HS_RPT_ACTIVE_OUT,
	output logic                      FS_RPT_ACTIVE_OUT,
	output logic [NUM_PORTS-1:0]      ROUTE_TT_OUT,
	output logic [NUM_PORTS-1:0]      RPT_RX_OUT,
	output logic [NUM_PORTS-1:0]      DN_DRIVE_OUT,
	output logic [NUM_PORTS-1:0]      UP_SRC_OUT,
	output logic                      UP_DRIVE_OUT,
	output logic                      RPT_BUSY_OUT
);

	initial begin
		if (NUM_PORTS < 1 || NUM_PORTS > 32) begin
			$error("hrr_core: NUM_PORTS must be 1 to 32");
		end
	end

	// Speed and routing state
	logic                 hs_q,      hs_d;
	logic                 fs_q,      fs_d;
	logic                 tt_q,      tt_d;
	logic                 hsr_q,     hsr_d;
	logic                 fsr_q,     fsr_d;
	logic [NUM_PORTS-1:0] rtt_q,     rtt_d;

	// Connectivity state
	hrr_state_e           st_q,      st_d;
	logic [NUM_PORTS-1:0] src_q,     src_d;
	logic [NUM_PORTS-1:0] drv_q,     drv_d;
	logic [NUM_PORTS-1:0] rx_q,      rx_d;
	logic                 updrv_q,   updrv_d;
	logic                 busy_q,    busy_d;

	logic [NUM_PORTS-1:0] rpt_ports;
	logic [NUM_PORTS-1:0] dn_req;
	logic [NUM_PORTS-1:0] dn_gnt;
	logic                 dn_any;

	// Route in force after this edge, so a start taken now matches the route it lands on
	assign rpt_ports = ~rtt_d;
	assign dn_req    = DN_SOP_IN & DN_ENABLED_IN & rpt_ports;

	hrr_pick #(
		.N       (NUM_PORTS)
	) u_pick (
		.req_in  (dn_req),
		.gnt_out (dn_gnt),
		.any_out (dn_any)
	);

	// Speed is only re-evaluated while idle so a route never flips mid-packet
	always_comb begin
		hs_d  = hs_q;
		fs_d  = fs_q;
		tt_d  = tt_q;
		hsr_d = hsr_q;
		fsr_d = fsr_q;
		rtt_d = rtt_q;
		if (st_q == HRR_IDLE) begin
			hs_d  = 1'b0;
			fs_d  = 1'b0;
			tt_d  = 1'b0;
			hsr_d = 1'b0;
			fsr_d = 1'b0;
			rtt_d = '0;
			if (UP_CONNECTED_IN) begin
				// [RQ1] High-speed operation
				hs_d  = UP_HIGH_SPEED_IN;
				// [RQ2] Full-speed operation
				fs_d  = !UP_HIGH_SPEED_IN;
				// [RQ3] HS functions off when full/low
				// [RQ5] FS repeater off when high-speed
				fsr_d = !UP_HIGH_SPEED_IN;
				// [RQ6] HS repeater serves HS devices
				hsr_d = UP_HIGH_SPEED_IN;
				// [RQ7] Full/low devices to translator
				// [RQ4] All ports to repeater when full/low
				rtt_d = UP_HIGH_SPEED_IN ? ~DN_HIGH_SPEED_IN : '0;
				// [RQ8] Translator serves split traffic under HS
				tt_d  = UP_HIGH_SPEED_IN;
			end
		end
	end

	always_comb begin
		st_d    = st_q;
		src_d   = src_q;
		drv_d   = drv_q;
		rx_d    = rx_q;
		updrv_d = updrv_q;
		case (st_q)
			HRR_IDLE: begin
				// [RQ10] No connection, all repeater-routed ports receiving
				src_d   = '0;
				drv_d   = '0;
				updrv_d = 1'b0;
				rx_d    = rpt_ports;
				if (UP_SOP_IN && UP_CONNECTED_IN) begin
					// [RQ12] Broadcast to enabled repeater-routed ports
					// [RQ13] Disabled ports excluded
					st_d  = HRR_DOWN;
					drv_d = DN_ENABLED_IN & rpt_ports;
					rx_d  = '0;
				end else if (dn_any && UP_CONNECTED_IN) begin
					// [RQ11] One port upstream only
					// [RQ9] Single upstream port
					st_d    = HRR_UP;
					src_d   = dn_gnt;
					updrv_d = 1'b1;
					rx_d    = dn_gnt;
				end
			end
			HRR_DOWN: begin
				// [RQ13] Port disabled mid-packet drops off
				drv_d = drv_q & DN_ENABLED_IN;
				// [RQ14] Tear down at packet end
				if (UP_EOP_IN || !UP_CONNECTED_IN) begin
					st_d  = HRR_IDLE;
					drv_d = '0;
					rx_d  = rpt_ports;
				end
			end
			HRR_UP: begin
				// [RQ14] Tear down at packet end
				if (|(DN_EOP_IN & src_q) || !(|(src_q & DN_ENABLED_IN))) begin
					st_d    = HRR_IDLE;
					src_d   = '0;
					updrv_d = 1'b0;
					rx_d    = rpt_ports;
				end
			end
			default: begin
				st_d    = HRR_IDLE;
				src_d   = '0;
				drv_d   = '0;
				updrv_d = 1'b0;
				rx_d    = rpt_ports;
			end
		endcase
		busy_d  = (st_d != HRR_IDLE);
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			hs_q    <= HRR_HS_MODE_RST;
			fs_q    <= 1'b0;
			tt_q    <= 1'b0;
			hsr_q   <= 1'b0;
			fsr_q   <= 1'b0;
			rtt_q   <= '0;
			st_q    <= HRR_IDLE;
			src_q   <= '0;
			drv_q   <= '0;
			rx_q    <= '0;
			updrv_q <= 1'b0;
			busy_q  <= 1'b0;
		end else begin
			hs_q    <= hs_d;
			fs_q    <= fs_d;
			tt_q    <= tt_d;
			hsr_q   <= hsr_d;
			fsr_q   <= fsr_d;
			rtt_q   <= rtt_d;
			st_q    <= st_d;
			src_q   <= src_d;
			drv_q   <= drv_d;
			rx_q    <= rx_d;
			updrv_q <= updrv_d;
			busy_q  <= busy_d;
		end
	end

	assign HS_MODE_OUT       = hs_q;
	assign FS_MODE_OUT       = fs_q;
	assign TT_ACTIVE_OUT     = tt_q;
	assign HS_RPT_ACTIVE_OUT = hsr_q;
	assign FS_RPT_ACTIVE_OUT = fsr_q;
	assign ROUTE_TT_OUT      = rtt_q;
	assign RPT_RX_OUT        = rx_q;
	assign DN_DRIVE_OUT      = drv_q;
	assign UP_SRC_OUT        = src_q;
	assign UP_DRIVE_OUT      = updrv_q;
	assign RPT_BUSY_OUT      = busy_q;

	// Checks
	chk_fs_no_hs: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ3]
		fs_q |-> !tt_q && !hsr_q && rtt_q == '0)
		else $error("HS function active in full-speed mode");
	chk_hs_no_fsr: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ5]
		hs_q |-> !fsr_q && !fs_q)
		else $error("FS repeater active in high-speed mode");
	chk_hs_mode_set: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ1]
		(st_q == HRR_IDLE && UP_CONNECTED_IN && UP_HIGH_SPEED_IN) |=> hs_q && hsr_q)
		else $error("high-speed mode not taken");
	chk_fs_mode_set: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ2]
		(st_q == HRR_IDLE && UP_CONNECTED_IN && !UP_HIGH_SPEED_IN) |=> fs_q && fsr_q)
		else $error("full-speed mode not taken");
	chk_tt_route: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ7]
		(st_q == HRR_IDLE && UP_CONNECTED_IN && UP_HIGH_SPEED_IN)
		|=> rtt_q == ~$past(DN_HIGH_SPEED_IN))
		else $error("translator routing wrong");
	chk_idle_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ10]
		(st_q == HRR_IDLE) |-> drv_q == '0 && !updrv_q)
		else $error("connection held while idle");
	chk_up_single: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ11]
		(st_q == HRR_UP) |-> $onehot(src_q) && drv_q == '0 && updrv_q)
		else $error("upstream connection not single port");
	chk_bcast_set: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ12]
		(st_q == HRR_IDLE && UP_SOP_IN && UP_CONNECTED_IN)
		|=> st_q == HRR_DOWN && drv_q == ($past(DN_ENABLED_IN) & ~rtt_q))
		else $error("broadcast set wrong");
	chk_no_disabled: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ13]
		(drv_q & ~$past(DN_ENABLED_IN)) == '0)
		else $error("disabled port driven");
	chk_teardown: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ14]
		(st_q == HRR_DOWN && UP_EOP_IN)
		|=> st_q == HRR_IDLE && drv_q == '0 && rx_q == ~rtt_q)
		else $error("no teardown after packet end");
	chk_pick_low: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // [RQ15]
		(st_q == HRR_IDLE && !UP_SOP_IN && UP_CONNECTED_IN && dn_any)
		|=> src_q == $past(dn_req & (~dn_req + 1'b1)))
		else $error("arbitration not lowest port");

endmodule

// *** tb/hrr_far_model.sv ***
// Far-side model: host and downstream devices framing packets
module hrr_far_model #(
	parameter int N = 4
) (
	input  wire logic         clk_in,
	output logic              up_sop_out,
	output logic              up_eop_out,
	output logic [N-1:0]      dn_sop_out,
	output logic [N-1:0]      dn_eop_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		up_sop_out = 1'b0;
		up_eop_out = 1'b0;
		dn_sop_out = '0;
		dn_eop_out = '0;
	end
	// One-cycle pulse; kind 0/1 host start/end, 2/3 device start/end
	task automatic pulse(input logic [1:0] kind, input logic [N-1:0] mask);
		@(posedge clk_in);
		up_sop_out <= (kind == 2'h0);
		up_eop_out <= (kind == 2'h1);
		dn_sop_out <= (kind == 2'h2) ? mask : '0;
		dn_eop_out <= (kind == 2'h3) ? mask : '0;
		@(posedge clk_in);
		up_sop_out <= 1'b0;
		up_eop_out <= 1'b0;
		dn_sop_out <= '0;
		dn_eop_out <= '0;
	endtask
endmodule

// *** tb/tb_hrr_core.sv ***
// Bench for speed selection, routing and packet connectivity
module tb_hrr_core;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = 4;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         conn = 1'b0;
	logic         up_hs = 1'b0;
	logic [N-1:0] dn_en = '0;
	logic [N-1:0] dn_hs = '0;
	logic         up_sop, up_eop, hs_m, fs_m, tt_a, hs_r, fs_r, up_drv, busy;
	logic [N-1:0] dn_sop, dn_eop, rt_tt, rx, drv, src;
	int           n_errors = 0;
	int           total_checks = 0;
	always #5 clk = ~clk;
	hrr_far_model #(.N(N)) far (.clk_in(clk), .up_sop_out(up_sop), .up_eop_out(up_eop),
		.dn_sop_out(dn_sop), .dn_eop_out(dn_eop));
	hrr_core #(.NUM_PORTS(N)) dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.UP_CONNECTED_IN(conn), .UP_HIGH_SPEED_IN(up_hs), .DN_ENABLED_IN(dn_en),
		.DN_HIGH_SPEED_IN(dn_hs), .UP_SOP_IN(up_sop), .UP_EOP_IN(up_eop),
		.DN_SOP_IN(dn_sop), .DN_EOP_IN(dn_eop), .HS_MODE_OUT(hs_m), .FS_MODE_OUT(fs_m),
		.TT_ACTIVE_OUT(tt_a), .HS_RPT_ACTIVE_OUT(hs_r), .FS_RPT_ACTIVE_OUT(fs_r),
		.ROUTE_TT_OUT(rt_tt), .RPT_RX_OUT(rx), .DN_DRIVE_OUT(drv), .UP_SRC_OUT(src),
		.UP_DRIVE_OUT(up_drv), .RPT_BUSY_OUT(busy));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	// Speed inputs are only taken while idle, so allow two edges
	task automatic set_env(input logic c, input logic h, input logic [N-1:0] e, d);
		@(posedge clk);
		conn <= c;
		up_hs <= h;
		dn_en <= e;
		dn_hs <= d;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic t_fs();
		set_env(1'b1, 1'b0, 4'hF, 4'h5);
		chk("hs_mode", 0, hs_m);
		chk("fs_mode", 1, fs_m);
		chk("tt_active", 0, tt_a);
		chk("hs_rpt", 0, hs_r);
		chk("fs_rpt", 1, fs_r);
		chk("route_tt", 4'h0, rt_tt);
		chk("rx_idle", 4'hF, rx);
	endtask
	task automatic t_bcast();
		set_env(1'b1, 1'b0, 4'h5, 4'h0);
		far.pulse(2'h0, 4'h0);
		#1;
		chk("bc_drive", 4'h5, drv);
		chk("bc_rx", 4'h0, rx);
		chk("bc_busy", 1, busy);
		far.pulse(2'h2, 4'h1);
		#1;
		chk("busy_up_drv", 0, up_drv);
		// Port 2 disabled mid-packet must drop off the broadcast
		set_env(1'b1, 1'b0, 4'h1, 4'h0);
		chk("drop_drive", 4'h1, drv);
		far.pulse(2'h1, 4'h0);
		#1;
		chk("end_drive", 4'h0, drv);
		chk("end_busy", 0, busy);
		chk("end_rx", 4'hF, rx);
	endtask
	task automatic t_dn();
		set_env(1'b1, 1'b0, 4'h7, 4'h0);
		far.pulse(2'h2, 4'hE);
		#1;
		chk("up_src", 4'h2, src);
		chk("up_drive", 1, up_drv);
		chk("no_dn_drive", 4'h0, drv);
		far.pulse(2'h3, 4'h2);
		#1;
		chk("dn_end_busy", 0, busy);
		// A start from a disabled port alone must not open a path
		far.pulse(2'h2, 4'h8);
		#1;
		chk("dis_busy", 0, busy);
	endtask
	task automatic t_hs();
		set_env(1'b1, 1'b1, 4'hF, 4'h5);
		chk("hs_mode", 1, hs_m);
		chk("hs_fs_mode", 0, fs_m);
		chk("hs_rx", 4'h5, rx);
		chk("fs_rpt", 0, fs_r);
		chk("hs_rpt", 1, hs_r);
		chk("route_tt", 4'hA, rt_tt);
		chk("tt_active", 1, tt_a);
		far.pulse(2'h0, 4'h0);
		#1;
		chk("hs_drive", 4'h5, drv);
		far.pulse(2'h1, 4'h0);
		#1;
		chk("hs_end_busy", 0, busy);
		// A start on a translator-routed port must not reach the repeater
		far.pulse(2'h2, 4'h2);
		#1;
		chk("tt_port_busy", 0, busy);
		far.pulse(2'h2, 4'h3);
		#1;
		chk("hs_up_src", 4'h1, src);
		far.pulse(2'h3, 4'h1);
		#1;
		chk("hs_up_end", 0, busy);
	endtask
	task automatic summarize();
		$display("Checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_errors++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk);
		#1;
		chk("rst_hs", 0, hs_m);
		chk("rst_rx", 4'h0, rx);
		@(posedge clk);
		rst_n <= 1'b1;
		t_fs();
		t_bcast();
		t_dn();
		t_hs();
		summarize();
	end
endmodule
